//--- common/ppa_pkg.sv
// Constants shared by the pass-through add-on port and its buffer.
// Assumes a single add-on clock for both sides of the port.
//
// How it works
// - Status outputs valid only while pending asserted
// - Status outputs update on next clock edge
// - Burst flag stays high for single phase
// - Two-bit region number of the hit region
// - Store flag high for writes, low reads
// - Low-active byte lanes; zero means all valid
// - Data-port read data appears one clock later
// - Lanes update one clock after data read
// - Done on final phase drops pending
// - New access accepted the clock after release
// - Bus released after cycle without read select
// - Address strobe drives address same cycle
// - Address then pipelined data saves a clock
// - Lanes update one clock after write strobe
// - Address register increments per burst phase
// - One word per clock with held done
// - Burst flag drops when last phase remains
// - Posting disabled: single word, no burst flag
package ppa_pkg;

    localparam int DATA_W = 32;
    localparam int LANE_W = 4;
    localparam int PHASE_W = 8;
    localparam int OFS_W = 5;
    localparam int BUF_W = DATA_W + LANE_W;

    // Data port byte offset, and its word index on the offset pins
    localparam logic [7:0] DATA_PORT_OFS = 8'h2c;
    localparam logic [OFS_W-1:0] DATA_PORT_IDX = DATA_PORT_OFS[6:2];

    localparam logic [LANE_W-1:0] LANES_ALL = 4'h0;
    localparam logic [LANE_W-1:0] LANES_NONE = 4'hf;
    localparam logic [DATA_W-1:0] ADDR_STEP = 32'h0000_0004;
    localparam logic [DATA_W-1:0] ADDR_RST = 32'h0000_0000;
    localparam logic [DATA_W-1:0] DATA_RST = 32'h0000_0000;
    localparam logic [DATA_W-1:0] UNMAPPED_DATA = 32'h0000_0000;
    localparam logic [1:0] REGION_RST = 2'h0;
    localparam logic [PHASE_W-1:0] PHASE_ONE = 8'h01;
    localparam logic [PHASE_W-1:0] PHASE_TWO = 8'h02;

    typedef enum logic [0:0]
    {
        ST_IDLE = 1'b0,
        ST_PEND = 1'b1
    } ppa_state_t;

endpackage

//--- logic/ppa_buf2.sv
// Two-entry buffer with valid/ready on both sides.
// Assumes both sides run on the same clock; exposes the entry behind the head.
`timescale 1ns/10ps

module ppa_buf2 #(
    parameter int W = 36
)
(
    // Clock and reset
    input wire logic clk,
    input wire logic nrst,
    // Filling side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [W-1:0] in_data,
    // Draining side
    output logic out_valid,
    input wire logic out_ready,
    output logic [W-1:0] out_data,
    output logic next_valid,
    output logic [W-1:0] next_data
);

    logic [W-1:0] mem [0:1];
    logic [1:0] count;
    logic push;
    logic pop;

    assign in_ready = (count != 2'h2);
    assign out_valid = (count != 2'h0);
    assign next_valid = (count == 2'h2);
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;
    assign out_data = mem[0];
    assign next_data = mem[1];

    ////////////////////////////////////////////////////////////////
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            count <= 2'h0;
        end
        else if (push && !pop)
        begin
            count <= count + 2'h1;
        end
        else if (pop && !push)
        begin
            count <= count - 2'h1;
        end
    end

    // Head always at slot 0, so a pop shifts slot 1 down
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            mem[0] <= '0;
            mem[1] <= '0;
        end
        else
        begin
            if (pop)
            begin
                mem[0] <= (push && count == 2'h1) ? in_data : mem[1];
            end
            else if (push && count == 2'h0)
            begin
                mem[0] <= in_data;
            end
            if (push && ((count == 2'h1 && !pop) || (count == 2'h2 && pop)))
            begin
                mem[1] <= in_data;
            end
        end
    end

endmodule

//--- logic/ppa_port.sv
// Add-on side of the pass-through port, passive mode.
// Assumes the PCI side hands over one access at a time, posts write words
// into the write stream and drains read words from the read stream.
`timescale 1ns/10ps

module ppa_port
(
    // Clock and reset
    input wire logic clk,
    input wire logic nrst,
    // Access hand-over from the PCI side
    input wire logic req_valid,
    output logic req_ready,
    input wire logic [1:0] req_region,
    input wire logic req_store,
    input wire logic [31:0] req_addr,
    input wire logic [7:0] req_phases,
    input wire logic [3:0] req_lanes_n,
    input wire logic post_burst_en,
    // Posted write words from the PCI side
    input wire logic wq_valid,
    output logic wq_ready,
    input wire logic [31:0] wq_data,
    input wire logic [3:0] wq_lanes_n,
    // Read words towards the PCI side
    output logic rq_valid,
    input wire logic rq_ready,
    output logic [31:0] rq_data,
    output logic [3:0] rq_lanes_n,
    // Pass-through status to the add-on
    output logic access_pending_n,
    output logic multi_phase_flag_n,
    output logic [1:0] region_id,
    output logic transfer_is_store,
    output logic [3:0] pending_byte_lanes_n,
    // Add-on handshake and address strobe
    input wire logic addon_done_n,
    input wire logic address_out_strobe_n,
    // Add-on register port
    input wire logic select_n,
    input wire logic [4:0] reg_offset,
    input wire logic [3:0] local_byte_en_n,
    input wire logic rd_n,
    input wire logic wr_n,
    input wire logic [31:0] dq_in,
    output logic [31:0] dq_out,
    output logic dq_oe
);

    ////////////////////////////////////////////////////////////////
    // Decode helpers

    function automatic logic hits_data_port(input logic [4:0] ofs);
        hits_data_port = (ofs == ppa_pkg::DATA_PORT_IDX);
    endfunction

    // Burst flag is low only while more than one phase remains
    function automatic logic burst_flag_n(input logic [7:0] phases);
        burst_flag_n = !(phases > ppa_pkg::PHASE_ONE);
    endfunction

    function automatic logic [31:0] lane_merge(
        input logic [31:0] data,
        input logic [3:0] lanes_n
    );
        logic [31:0] r;
        r = '0;
        for (int i = 0; i < 4; i++)
        begin
            if (!lanes_n[i])
            begin
                r[i*8 +: 8] = data[i*8 +: 8];
            end
        end
        lane_merge = r;
    endfunction

    ////////////////////////////////////////////////////////////////
    // Declarations

    ppa_pkg::ppa_state_t state;
    logic [31:0] addr_reg;
    logic [7:0] phases_left;
    logic [3:0] read_lanes_n;
    logic take_req;
    logic rd_sel;
    logic wr_sel;
    logic rd_data;
    logic wr_data;
    logic done_seen;
    logic last_phase;
    logic [7:0] next_phases;
    logic [31:0] dq_pipe;
    logic dq_pipe_oe;
    logic addr_strobe;
    logic [35:0] head;
    logic [35:0] behind;
    logic head_valid;
    logic behind_valid;
    logic [35:0] rq_word;

    ////////////////////////////////////////////////////////////////
    // Strobe decode; inputs are on the add-on clock, so no synchroniser

    assign rd_sel = !select_n && !rd_n;
    assign wr_sel = !select_n && !wr_n;
    assign rd_data = rd_sel && hits_data_port(reg_offset);
    assign wr_data = wr_sel && hits_data_port(reg_offset);
    assign addr_strobe = !address_out_strobe_n;

    assign done_seen = (state == ppa_pkg::ST_PEND) && !addon_done_n;
    assign last_phase = (phases_left <= ppa_pkg::PHASE_ONE);

    assign req_ready = (state == ppa_pkg::ST_IDLE);
    assign take_req = req_valid && req_ready;

    // Posting disabled for bursts: a store is cut to one phase
    always_comb
    begin
        if (req_store && !post_burst_en)
        begin
            next_phases = ppa_pkg::PHASE_ONE;
        end
        else if (req_phases == 8'h00)
        begin
            next_phases = ppa_pkg::PHASE_ONE;
        end
        else
        begin
            next_phases = req_phases;
        end
    end

    ////////////////////////////////////////////////////////////////
    // Access state and pending flag

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            state <= ppa_pkg::ST_IDLE;
            access_pending_n <= 1'b1;
        end
        else
        begin
            case (state)
                ppa_pkg::ST_IDLE:
                begin
                    if (take_req)
                    begin
                        state <= ppa_pkg::ST_PEND;
                        access_pending_n <= 1'b0;
                    end
                end
                ppa_pkg::ST_PEND:
                begin
                    if (done_seen && last_phase)
                    begin
                        state <= ppa_pkg::ST_IDLE;
                        access_pending_n <= 1'b1;
                    end
                end
                default:
                begin
                    state <= ppa_pkg::ST_IDLE;
                    access_pending_n <= 1'b1;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////
    // Region, direction; held for the whole access

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            region_id <= ppa_pkg::REGION_RST;
            transfer_is_store <= 1'b0;
        end
        else if (take_req)
        begin
            region_id <= req_region;
            transfer_is_store <= req_store;
        end
    end

    ////////////////////////////////////////////////////////////////
    // Phase count and burst flag

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            phases_left <= ppa_pkg::PHASE_ONE;
            multi_phase_flag_n <= 1'b1;
        end
        else if (take_req)
        begin
            phases_left <= next_phases;
            multi_phase_flag_n <= burst_flag_n(next_phases);
        end
        else if (done_seen && !last_phase)
        begin
            phases_left <= phases_left - ppa_pkg::PHASE_ONE;
            multi_phase_flag_n <= (phases_left <= ppa_pkg::PHASE_TWO);
        end
        else if (done_seen)
        begin
            multi_phase_flag_n <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////
    // Captured address, stepped on each completed phase but the last

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            addr_reg <= ppa_pkg::ADDR_RST;
        end
        else if (take_req)
        begin
            addr_reg <= req_addr;
        end
        else if (done_seen && !last_phase)
        begin
            addr_reg <= addr_reg + ppa_pkg::ADDR_STEP;
        end
    end

    ////////////////////////////////////////////////////////////////
    // Byte-lane outputs

    // Lanes show the head word while one waits, otherwise the word still owed
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            pending_byte_lanes_n <= ppa_pkg::LANES_NONE;
            read_lanes_n <= ppa_pkg::LANES_ALL;
        end
        else if (take_req)
        begin
            pending_byte_lanes_n <= req_lanes_n;
            read_lanes_n <= req_lanes_n;
        end
        else if (state == ppa_pkg::ST_PEND && transfer_is_store && rd_data)
        begin
            if (head_valid && behind_valid)
            begin
                pending_byte_lanes_n <= behind[35:32];
            end
            else
            begin
                pending_byte_lanes_n <= ppa_pkg::LANES_NONE;
            end
        end
        else if (state == ppa_pkg::ST_PEND && !transfer_is_store && wr_data)
        begin
            if (last_phase)
            begin
                pending_byte_lanes_n <= ppa_pkg::LANES_NONE;
            end
            else
            begin
                pending_byte_lanes_n <= read_lanes_n;
            end
        end
        else if (state == ppa_pkg::ST_PEND && transfer_is_store && head_valid)
        begin
            // A word posted after the lanes went idle is shown once it lands
            if (pending_byte_lanes_n == ppa_pkg::LANES_NONE)
            begin
                pending_byte_lanes_n <= head[35:32];
            end
        end
    end

    ////////////////////////////////////////////////////////////////
    // Write path: posted words wait here until the add-on reads them

    ppa_buf2 #(
        .W(ppa_pkg::BUF_W)
    ) u_wbuf (
        .clk(clk),
        .nrst(nrst),
        .in_valid(wq_valid),
        .in_ready(wq_ready),
        .in_data({wq_lanes_n, wq_data}),
        .out_valid(head_valid),
        .out_ready(rd_data),
        .out_data(head),
        .next_valid(behind_valid),
        .next_data(behind)
    );

    ////////////////////////////////////////////////////////////////
    // Read path: add-on writes land here; a stall on the PCI side
    // loses no word while at most two are outstanding

    assign rq_word = {local_byte_en_n, lane_merge(dq_in, local_byte_en_n)};

    ppa_buf2 #(
        .W(ppa_pkg::BUF_W)
    ) u_rbuf (
        .clk(clk),
        .nrst(nrst),
        .in_valid(wr_data),
        .in_ready(),
        .in_data(rq_word),
        .out_valid(rq_valid),
        .out_ready(rq_ready),
        .out_data({rq_lanes_n, rq_data}),
        .next_valid(),
        .next_data()
    );

    ////////////////////////////////////////////////////////////////
    // Data bus

    // Pipelined register read; unmapped offsets answer with zero
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            dq_pipe <= ppa_pkg::DATA_RST;
            dq_pipe_oe <= 1'b0;
        end
        else
        begin
            dq_pipe_oe <= rd_sel;
            if (rd_data)
            begin
                dq_pipe <= head[31:0];
            end
            else if (rd_sel)
            begin
                dq_pipe <= ppa_pkg::UNMAPPED_DATA;
            end
        end
    end

    // Address strobe bypasses the pipeline; a read issued with it shows
    // its data the clock after; if the strobe is still low then, the address wins
    always_comb
    begin
        if (addr_strobe)
        begin
            dq_out = addr_reg;
        end
        else
        begin
            dq_out = dq_pipe;
        end
        // Contention with an add-on write is left to the add-on
        dq_oe = addr_strobe || dq_pipe_oe;
    end

endmodule

//--- verif/ppa_chk.sv
// Checker of the pass-through add-on port, bound to its top module.
// Assumes one clock; the active-low reset disables every property.
`timescale 1ns/10ps
module ppa_chk
(
    // Clock and reset
    input wire logic clk,
    input wire logic nrst,
    // Hand-over side
    input wire logic req_valid,
    input wire logic req_ready,
    input wire logic [1:0] req_region,
    input wire logic req_store,
    input wire logic [7:0] req_phases,
    // Add-on side
    input wire logic access_pending_n,
    input wire logic multi_phase_flag_n,
    input wire logic [1:0] region_id,
    input wire logic transfer_is_store,
    input wire logic addon_done_n,
    input wire logic address_out_strobe_n,
    input wire logic select_n,
    input wire logic rd_n,
    input wire logic dq_oe
);
////////////////////////////////////////////////////////////
default clocking @(posedge clk);
endclocking
default disable iff (!nrst);
sequence take_s;
    req_valid && req_ready;
endsequence
sequence last_s;
    !access_pending_n && !addon_done_n && multi_phase_flag_n;
endsequence
sequence rd_s;
    !select_n && !rd_n;
endsequence
take_load_a: assert property (take_s |=> !access_pending_n
    && region_id == $past(req_region) && transfer_is_store == $past(req_store))
    else $error("status not loaded");
one_phase_a: assert property (req_valid && req_ready && req_phases <= 8'h01
    |=> multi_phase_flag_n) else $error("burst flag on single phase");
last_done_a: assert property (last_s |=> access_pending_n)
    else $error("pending kept after last done");
wait_hold_a: assert property (!access_pending_n && addon_done_n
    |=> !access_pending_n) else $error("pending dropped without done");
region_keep_a: assert property (!access_pending_n ##1 !access_pending_n
    |-> $stable(region_id) && $stable(transfer_is_store)) else $error("status moved");
busy_refuse_a: assert property (!access_pending_n |-> !req_ready)
    else $error("access offered while pending");
free_again_a: assert property ($rose(access_pending_n) |-> req_ready)
    else $error("not free after release");
addr_now_a: assert property (!address_out_strobe_n |-> dq_oe)
    else $error("address not driven");
read_pipe_a: assert property (rd_s |=> dq_oe)
    else $error("read data not driven");
bus_free_a: assert property (!(!select_n && !rd_n) ##1 address_out_strobe_n
    |-> !dq_oe) else $error("bus not released");
endmodule
bind ppa_port ppa_chk chk (.*);

//--- verif/ppa_addon.sv
// Add-on logic model: drives the register port, address strobe and done.
// Assumes the bench calls one task at a time.
`timescale 1ns/10ps
module ppa_addon
(
    // Clock and device bus
    input wire logic clk,
    input wire logic [31:0] dq_out,
    input wire logic dq_oe,
    // Add-on controls
    output logic addon_done_n,
    output logic address_out_strobe_n,
    output logic select_n,
    output logic [4:0] reg_offset,
    output logic [3:0] local_byte_en_n,
    output logic rd_n,
    output logic wr_n,
    output logic [31:0] dq_in
);
logic [31:0] drv = 32'h0;
////////////////////////////////////////////////////////////
// Floating bus shows the inverse of our last word, so a stale latch cannot match
assign dq_in = !wr_n ? drv : (dq_oe ? dq_out : ~drv);
initial
begin
    addon_done_n = 1'h1;
    address_out_strobe_n = 1'h1;
    select_n = 1'h1;
    reg_offset = 5'h0;
    local_byte_en_n = 4'h0;
    rd_n = 1'h1;
    wr_n = 1'h1;
end
// Strobe, read, write and done are low active
task automatic drive(input logic s, input logic r, input logic w, input logic d,
    input logic [3:0] be, input logic [4:0] o, input logic [31:0] v);
    @(posedge clk);
    address_out_strobe_n <= s;
    rd_n <= r;
    wr_n <= w | ~s;
    select_n <= r & w;
    reg_offset <= o;
    local_byte_en_n <= be;
    addon_done_n <= d;
    drv <= v;
    @(negedge clk);
endtask
endmodule

//--- verif/ppa_port_test.sv
// Testbench of the pass-through add-on port: PCI side here, add-on side in the model.
// Assumes the checker is bound to the design top.
`timescale 1ns/10ps
module ppa_port_test;
localparam logic [4:0] DP = ppa_pkg::DATA_PORT_IDX;
logic clk = 1'h0;
logic nrst = 1'h0;
logic req_valid = 1'h0;
logic req_store = 1'h0;
logic post_burst_en = 1'h1;
logic wq_valid = 1'h0;
logic rq_ready = 1'h0;
logic [1:0] req_region = 2'h0;
logic [7:0] req_phases = 8'h01;
logic [3:0] req_lanes_n = 4'hf;
logic [3:0] wq_lanes_n = 4'hf;
logic [31:0] req_addr = 32'h0;
logic [31:0] wq_data = 32'h0;
logic req_ready, wq_ready, rq_valid, access_pending_n, multi_phase_flag_n;
logic transfer_is_store, addon_done_n, address_out_strobe_n, select_n, rd_n, wr_n, dq_oe;
logic [1:0] region_id;
logic [3:0] rq_lanes_n, pending_byte_lanes_n, local_byte_en_n;
logic [4:0] reg_offset;
logic [31:0] rq_data, dq_in, dq_out;
int failures = 0;
int cmp_count = 0;
ppa_port dut (.*);
ppa_addon addon (.*);
always #4 clk = ~clk;
////////////////////////////////////////////////////////////
task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e)
    begin
        failures++;
        $display("[ERR] %s expected %h seen %h", n, e, g);
    end
endtask
task automatic close_out();
    $display("Checks %0d, mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0)
        $display("Result: passed");
    else
        $display("Result: failed");
    $finish;
endtask
task automatic status(input logic b, input logic [1:0] r, input logic s, input logic [3:0] l);
    chk("pending", 32'h0, access_pending_n);
    chk("burst", b, multi_phase_flag_n);
    chk("region", r, region_id);
    chk("store", s, transfer_is_store);
    chk("lanes", l, pending_byte_lanes_n);
endtask
task automatic offer(input logic [1:0] r, input logic s, input logic [31:0] a,
    input logic [7:0] p, input logic [3:0] l, input logic pb);
    @(posedge clk);
    req_valid <= 1'h1;
    req_region <= r;
    req_store <= s;
    req_addr <= a;
    req_phases <= p;
    req_lanes_n <= l;
    post_burst_en <= pb;
    @(posedge clk);
    req_valid <= 1'h0;
    @(negedge clk);
endtask
task automatic push(input logic [31:0] d, input logic [3:0] l);
    @(posedge clk);
    wq_valid <= 1'h1;
    wq_data <= d;
    wq_lanes_n <= l;
    @(negedge clk);
    while (!wq_ready)
        @(negedge clk);
    @(posedge clk);
    wq_valid <= 1'h0;
endtask
task automatic op(input logic s, input logic r, input logic w, input logic d);
    addon.drive(s, r, w, d, 4'h0, DP, 32'h0);
endtask
initial
begin
    repeat (5) @(posedge clk);
    nrst <= 1'h1;
    // Idle status after reset, then an unmapped offset
    addon.drive(1'h1, 1'h0, 1'h1, 1'h1, 4'h0, 5'h00, 32'h0);
    chk("idle pending", 32'h1, access_pending_n);
    chk("idle lanes", 32'hf, pending_byte_lanes_n);
    chk("idle ready", 32'h1, req_ready);
    op(1'h1, 1'h1, 1'h1, 1'h1);
    chk("unmapped", ppa_pkg::UNMAPPED_DATA, dq_out);
    chk("unmapped oe", 32'h1, dq_oe);
    // Single store, zero phases taken as one, address and read in one cycle
    push(32'h1111_2222, 4'h0);
    offer(2'h1, 1'h1, 32'h100, 8'h00, 4'h0, 1'h1);
    status(1'h1, 2'h1, 1'h1, 4'h0);
    op(1'h0, 1'h0, 1'h1, 1'h0);
    chk("addr", 32'h100, dq_out);
    op(1'h1, 1'h1, 1'h1, 1'h1);
    chk("data", 32'h1111_2222, dq_out);
    chk("lanes", 32'hf, pending_byte_lanes_n);
    chk("pending", 32'h1, access_pending_n);
    op(1'h1, 1'h1, 1'h1, 1'h1);
    chk("oe", 32'h0, dq_oe);
    // Burst with done held, buffer filled until it refuses
    push(32'ha1, 4'h3);
    push(32'ha2, 4'hc);
    @(negedge clk);
    chk("wq full", 32'h0, wq_ready);
    offer(2'h3, 1'h1, 32'h200, 8'h02, 4'h3, 1'h1);
    status(1'h0, 2'h3, 1'h1, 4'h3);
    op(1'h0, 1'h0, 1'h1, 1'h0);
    op(1'h1, 1'h0, 1'h1, 1'h0);
    chk("data", 32'ha1, dq_out);
    chk("lanes", 32'hc, pending_byte_lanes_n);
    chk("burst", 32'h1, multi_phase_flag_n);
    op(1'h1, 1'h1, 1'h1, 1'h1);
    chk("data", 32'ha2, dq_out);
    chk("pending", 32'h1, access_pending_n);
    // Slow burst: strobe before each read, done withheld between phases
    fork
        begin
            push(32'hb0, 4'h1);
            push(32'hb1, 4'h2);
            push(32'hb2, 4'h4);
        end
    join_none
    offer(2'h3, 1'h1, 32'h300, 8'h03, 4'h1, 1'h1);
    status(1'h0, 2'h3, 1'h1, 4'h1);
    for (int k = 0; k < 3; k++)
    begin
        op(1'h0, 1'h1, 1'h1, 1'h1);
        chk("addr", 32'h300 + 32'h4 * k, dq_out);
        op(1'h1, 1'h0, 1'h1, 1'h0);
        chk("oe", 32'h0, dq_oe);
        chk("pending", 32'h0, access_pending_n);
        op(1'h1, 1'h1, 1'h1, 1'h1);
        chk("data", 32'hb0 + k, dq_out);
        chk("lanes", (k == 2) ? 32'hf : (32'h2 << k), pending_byte_lanes_n);
    end
    chk("pending", 32'h1, access_pending_n);
    // Load burst with the read stream stalled, then drained
    offer(2'h2, 1'h0, 32'h400, 8'h02, 4'h5, 1'h1);
    status(1'h0, 2'h2, 1'h0, 4'h5);
    op(1'h0, 1'h1, 1'h1, 1'h1);
    chk("addr", 32'h400, dq_out);
    op(1'h1, 1'h1, 1'h1, 1'h1);
    chk("oe", 32'h0, dq_oe);
    addon.drive(1'h1, 1'h1, 1'h0, 1'h0, 4'h0, DP, 32'hc0c1_c2c3);
    addon.drive(1'h1, 1'h1, 1'h0, 1'h0, 4'h3, DP, 32'hd0d1_d2d3);
    chk("rq", 32'hc0c1_c2c3, rq_data);
    chk("rq lanes", 32'h0, rq_lanes_n);
    chk("lanes", 32'h5, pending_byte_lanes_n);
    op(1'h1, 1'h1, 1'h1, 1'h1);
    chk("pending", 32'h1, access_pending_n);
    chk("lanes", 32'hf, pending_byte_lanes_n);
    chk("rq held", 32'hc0c1_c2c3, rq_data);
    @(posedge clk);
    rq_ready <= 1'h1;
    @(posedge clk);
    @(negedge clk);
    chk("rq masked", 32'hd0d1_0000, rq_data);
    chk("rq lanes", 32'h3, rq_lanes_n);
    @(negedge clk);
    chk("rq empty", 32'h0, rq_valid);
    // Posting disabled: burst store cut to one phase
    push(32'he0, 4'h0);
    offer(2'h0, 1'h1, 32'h500, 8'h04, 4'h0, 1'h0);
    status(1'h1, 2'h0, 1'h1, 4'h0);
    op(1'h1, 1'h0, 1'h1, 1'h0);
    op(1'h1, 1'h1, 1'h1, 1'h1);
    chk("data", 32'he0, dq_out);
    chk("pending", 32'h1, access_pending_n);
    close_out();
end
// Whole run needs some 50 cycles
initial
begin
    repeat (2000) @(posedge clk);
    failures++;
    close_out();
end
endmodule
